// *** logic/iackc_pkg.sv ***
package iackc_pkg;
  // Acknowledge bus cycle encodings
  localparam logic [1:0]  TT_ACK        = 2'h3;
  localparam logic [31:0] ADDR_ALL_ONES = 32'hffffffff;
  localparam logic [7:0]  AUTOVEC_BASE  = 8'h18;
  localparam logic [7:0]  SPURIOUS_VEC  = 8'h18;
  localparam logic [2:0]  LEVEL_NONE    = 3'h0;
  localparam logic [2:0]  LEVEL_IDLE_N  = 3'h7;

  // Register map, byte addresses
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_VECTOR = 4'h8;

  // Control: priority mask field
  localparam int          CTRL_MASK_LSB = 0;
  localparam logic [2:0]  MASK_RESET    = 3'h7;
  // Status fields
  localparam int STAT_PEND_BIT  = 0;
  localparam int STAT_BUSY_BIT  = 1;
  localparam int STAT_HNDL_BIT  = 2;
  localparam int STAT_LEVEL_LSB = 4;
  localparam int STAT_PLVL_LSB  = 8;
  // Vector fields
  localparam int VEC_NUM_LSB  = 0;
  localparam int VEC_KIND_LSB = 8;

  typedef enum logic [1:0] {
    KIND_VECTORED,
    KIND_AUTO,
    KIND_SPURIOUS,
    KIND_NONE
  } iackc_kind_type;
endpackage : iackc_pkg

// *** logic/iackc_lvl_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface iackc_lvl_if;
  logic [2:0] level;
  modport src (output level);
  modport dst (input  level);
endinterface : iackc_lvl_if
`default_nettype wire

// *** logic/iackc_level_filter.sv ***
`timescale 1ns/1ns
`default_nettype none
module iackc_level_filter (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Request pins, active low
  input  wire logic [2:0] irq_level_n,
  // Accepted level, active high
  iackc_lvl_if.src        lvl
);
  logic [2:0] samp_q;
  logic [2:0] level_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      samp_q <= iackc_pkg::LEVEL_IDLE_N;
    end else begin
      samp_q <= irq_level_n;
    end
  end

  // Accepted only when equal at two consecutive edges
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      level_q <= iackc_pkg::LEVEL_NONE;
    end else if (irq_level_n == samp_q) begin // RL3
      level_q <= ~irq_level_n;
    end
  end

  assign lvl.level = level_q;

  AST_LEVEL_STABLE: assert property (@(posedge core_clk) disable iff (!rstn) // RL3
    (level_q != $past(level_q)) |->
      ($past(irq_level_n) == $past(irq_level_n, 2)) && (level_q == ~$past(irq_level_n)))
    else $error("Level accepted without two stable samples");
endmodule : iackc_level_filter
`default_nettype wire

// *** logic/iackc_top.sv ***
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
// What this block, its requester and the termination logic do
// RL1: Requester drives a nonzero active-low priority level onto the level inputs.
// RL2: Request becomes pending only when its level exceeds the priority mask.
// RL3: Level inputs sampled every edge; valid once equal at two consecutive edges.
// RL4: Requester holds its level until its acknowledge cycle has run.
// RL5: Pending output asserts whenever a request is pending.
// RL6: Pending output negates at internal acknowledge, on the same edge that starts the bus cycle.
// RL7: Interrupt taken at boundary; one handler instruction before next recognition.
// RL8: Acknowledge is a read with transfer type outputs equal to three.
// RL9: All address lines high during the acknowledge read.
// RL10: Transfer modifier carries the acknowledged level, inverse of the inputs.
// RL11: Ack without autovector: latch vector byte from low data byte.
// RL12: Autovector input sampled only when transfer acknowledge is asserted.
// RL13: Autovector: ignore data, vector is level plus 24.
// RL14: Seven distinct autovectors, one per request level.
// RL15: Error without acknowledge gives spurious vector 24.
// RL16: Acknowledge together with error terminates and retries the cycle.
// RL17: Autovector input may be held asserted when every source autovectors.
// RL18: Neither acknowledge nor error: insert wait, keep sampling each edge.
// RL19: Termination logic changes acknowledge and error on the same edge.
// RL20: Level zero is no request and never becomes pending.
module iackc_top (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt request and pending pins
  input  wire logic [2:0]  irq_level_n,
  output logic             irq_pending_n,
  // External bus
  output logic [31:0]      bus_addr,
  output logic             transfer_type_hi,
  output logic             transfer_type_lo,
  output logic [2:0]       transfer_modifier,
  output logic             bus_read,
  output logic             transfer_start_n,
  input  wire logic [7:0]  bus_data_in,
  input  wire logic        transfer_ack_n,
  input  wire logic        transfer_error_ack_n,
  input  wire logic        autovector_req_n,
  // Execution core side
  input  wire logic        instr_boundary,
  input  wire logic        higher_exc_pending,
  output logic             exc_take,
  output logic [7:0]       exc_vector,
  output logic [1:0]       exc_kind
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PEND,
    ST_START,
    ST_WAIT,
    ST_HANDLER
  } iackc_state_type;

  iackc_state_type state_q;
  logic [2:0]      mask_q;
  logic [2:0]      pend_level_q;
  logic            pend_n_q;
  logic [31:0]     addr_q;
  logic [1:0]      tt_q;
  logic [2:0]      tm_q;
  logic            read_q;
  logic            ts_n_q;
  logic            take_q;
  logic [7:0]      vector_q;
  iackc_pkg::iackc_kind_type kind_q;
  logic            wait_q;
  logic [31:0]     rdata_q;

  logic            bus_ta;
  logic            bus_tea;
  logic            internal_ack;
  logic            request_ok;
  logic            mask_wr;
  logic [2:0]      cur_level;

  iackc_lvl_if lvl ();

  iackc_level_filter iackc_level_filter_inst (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .irq_level_n (irq_level_n),
    .lvl         (lvl.src)
  );

  assign cur_level    = lvl.level;
  assign bus_ta       = !transfer_ack_n;
  assign bus_tea      = !transfer_error_ack_n;
  // Exception taken at a boundary once higher exceptions are out of the way
  assign internal_ack = (state_q == ST_PEND) && instr_boundary && !higher_exc_pending; // RL7
  assign request_ok   = (cur_level != iackc_pkg::LEVEL_NONE) // RL20
                      && (cur_level > mask_q); // RL2
  assign mask_wr      = avs_write && !wait_q && (avs_address == iackc_pkg::REG_CTRL);

  // Sequencer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (request_ok) begin
            state_q <= ST_PEND;
          end
        end
        ST_PEND: begin
          if (internal_ack) begin
            state_q <= ST_START;
          end
        end
        ST_START: begin
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (bus_ta && bus_tea) begin
            state_q <= ST_START; // RL16
          end else if (bus_ta || bus_tea) begin
            state_q <= ST_HANDLER;
          end
        end
        ST_HANDLER: begin
          // Nothing is recognized until a handler instruction has completed
          if (instr_boundary) begin
            state_q <= ST_IDLE; // RL7
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Pending level is frozen when the request becomes pending
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_level_q <= iackc_pkg::LEVEL_NONE;
    end else if ((state_q == ST_IDLE) && request_ok) begin
      pend_level_q <= cur_level;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_n_q <= 1'b1;
    end else if ((state_q == ST_IDLE) && request_ok) begin
      pend_n_q <= 1'b0; // RL5
    end else if (internal_ack) begin
      pend_n_q <= 1'b1; // RL6
    end
  end

  // Taking the exception raises the mask to the taken level; this wins
  // over a software write in the same cycle.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= iackc_pkg::MASK_RESET;
    end else if (take_q) begin
      mask_q <= pend_level_q;
    end else if (mask_wr) begin
      mask_q <= avs_writedata[iackc_pkg::CTRL_MASK_LSB +: 3];
    end
  end

  // Acknowledge bus cycle attributes; retry reuses the same attributes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      addr_q <= 32'h0;
      tt_q   <= 2'h0;
      tm_q   <= 3'h0;
      read_q <= 1'b0;
      ts_n_q <= 1'b1;
    end else if (internal_ack || ((state_q == ST_WAIT) && bus_ta && bus_tea)) begin
      addr_q <= iackc_pkg::ADDR_ALL_ONES; // RL9
      tt_q   <= iackc_pkg::TT_ACK; // RL8
      tm_q   <= pend_level_q; // RL10
      read_q <= 1'b1; // RL8
      ts_n_q <= 1'b0;
    end else if (state_q == ST_START) begin
      ts_n_q <= 1'b1;
    end else if ((state_q == ST_WAIT) && (bus_ta || bus_tea)) begin
      addr_q <= 32'h0;
      tt_q   <= 2'h0;
      tm_q   <= 3'h0;
      read_q <= 1'b0;
    end
  end

  // Termination decode; with neither strobe the cycle simply waits
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      take_q   <= 1'b0;
      vector_q <= 8'h0;
      kind_q   <= iackc_pkg::KIND_NONE;
    end else begin
      take_q <= 1'b0; // RL18
      if (state_q == ST_WAIT) begin
        if (bus_ta && !bus_tea) begin
          take_q <= 1'b1;
          if (!autovector_req_n) begin // RL12
            vector_q <= iackc_pkg::AUTOVEC_BASE + {5'h0, pend_level_q}; // RL13 RL14
            kind_q   <= iackc_pkg::KIND_AUTO;
          end else begin
            vector_q <= bus_data_in; // RL11
            kind_q   <= iackc_pkg::KIND_VECTORED;
          end
        end else if (bus_tea && !bus_ta) begin
          take_q   <= 1'b1;
          vector_q <= iackc_pkg::SPURIOUS_VEC; // RL15
          kind_q   <= iackc_pkg::KIND_SPURIOUS;
        end
      end
    end
  end

  // Avalon slave: one wait cycle, then the answer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 1'b1;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0;
    end else if (avs_read && wait_q) begin
      rdata_q <= 32'h0;
      case (avs_address)
        iackc_pkg::REG_CTRL: begin
          rdata_q[iackc_pkg::CTRL_MASK_LSB +: 3] <= mask_q;
        end
        iackc_pkg::REG_STATUS: begin
          rdata_q[iackc_pkg::STAT_PEND_BIT]       <= !pend_n_q;
          rdata_q[iackc_pkg::STAT_BUSY_BIT]       <= (state_q == ST_START)
                                                  || (state_q == ST_WAIT);
          rdata_q[iackc_pkg::STAT_HNDL_BIT]       <= (state_q == ST_HANDLER);
          rdata_q[iackc_pkg::STAT_LEVEL_LSB +: 3] <= cur_level;
          rdata_q[iackc_pkg::STAT_PLVL_LSB +: 3]  <= pend_level_q;
        end
        iackc_pkg::REG_VECTOR: begin
          rdata_q[iackc_pkg::VEC_NUM_LSB +: 8]  <= vector_q;
          rdata_q[iackc_pkg::VEC_KIND_LSB +: 2] <= kind_q;
        end
        default: begin
          rdata_q <= 32'h0;
        end
      endcase
    end
  end

  assign avs_readdata      = rdata_q;
  assign avs_waitrequest   = wait_q;
  assign irq_pending_n     = pend_n_q;
  assign bus_addr          = addr_q;
  assign transfer_type_hi  = tt_q[1];
  assign transfer_type_lo  = tt_q[0];
  assign transfer_modifier = tm_q;
  assign bus_read          = read_q;
  assign transfer_start_n  = ts_n_q;
  assign exc_take          = take_q;
  assign exc_vector        = vector_q;
  assign exc_kind          = kind_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  AST_PEND_ABOVE_MASK: assert property ( // RL2
    $fell(pend_n_q) |-> ($past(cur_level) > $past(mask_q)))
    else $error("Pending set for a level not above mask");
  AST_NO_ZERO_PEND: assert property ( // RL20
    !pend_n_q |-> (pend_level_q != iackc_pkg::LEVEL_NONE))
    else $error("Level zero made pending");
  AST_PEND_ASSERT: assert property ( // RL5
    ((state_q == ST_IDLE) && request_ok) |=> !irq_pending_n && (state_q == ST_PEND))
    else $error("Pending output not asserted");
  AST_PEND_NEGATE: assert property ( // RL6
    internal_ack |=> irq_pending_n && !transfer_start_n)
    else $error("Pending not negated at internal acknowledge");
  AST_ACK_ATTRS: assert property ( // RL8
    !transfer_start_n |-> transfer_type_hi && transfer_type_lo && bus_read)
    else $error("Acknowledge cycle attributes wrong");
  AST_ADDR_ONES: assert property ( // RL9
    !transfer_start_n |-> (bus_addr == iackc_pkg::ADDR_ALL_ONES))
    else $error("Address not all ones");
  AST_TM_LEVEL: assert property ( // RL10
    !transfer_start_n |-> (transfer_modifier == pend_level_q) ##1 (transfer_modifier == pend_level_q))
    else $error("Modifier does not carry level");
  AST_VECTORED: assert property ( // RL11
    ((state_q == ST_WAIT) && bus_ta && !bus_tea && autovector_req_n)
      |=> exc_take && (exc_vector == $past(bus_data_in)))
    else $error("Vector byte not latched");
  AST_AUTOVEC: assert property ( // RL13
    ((state_q == ST_WAIT) && bus_ta && !bus_tea && !autovector_req_n)
      |=> exc_take && (exc_vector == (iackc_pkg::AUTOVEC_BASE + {5'h0, pend_level_q})))
    else $error("Autovector value wrong");
  AST_SPURIOUS: assert property ( // RL15
    ((state_q == ST_WAIT) && !bus_ta && bus_tea)
      |=> exc_take && (exc_vector == iackc_pkg::SPURIOUS_VEC))
    else $error("Spurious vector wrong");
  AST_RETRY: assert property ( // RL16
    ((state_q == ST_WAIT) && bus_ta && bus_tea) |=> !exc_take && !transfer_start_n ##1 transfer_start_n)
    else $error("Retry not started");
  AST_WAIT_STATE: assert property ( // RL18
    ((state_q == ST_WAIT) && !bus_ta && !bus_tea) |=> (state_q == ST_WAIT) && !exc_take)
    else $error("Wait state not inserted");
  AST_HANDLER_HOLD: assert property ( // RL7
    exc_take |-> (state_q == ST_HANDLER) && irq_pending_n)
    else $error("Recognition before handler instruction");

  COV_VECTORED: cover property (exc_take && (exc_kind == iackc_pkg::KIND_VECTORED));
  COV_AUTO: cover property (exc_take && (exc_kind == iackc_pkg::KIND_AUTO));
  COV_SPURIOUS: cover property (exc_take && (exc_kind == iackc_pkg::KIND_SPURIOUS));
  COV_RETRY: cover property ((state_q == ST_WAIT) && bus_ta && bus_tea);
endmodule : iackc_top
`default_nettype wire

// *** testbench/iackc_peer.sv ***
`timescale 1ns/1ns
`default_nettype none
module iackc_peer (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Bench commands: 0 vectored, 1 auto, 2 error, 3 retry then vectored
  input  wire logic [2:0] req_level,
  input  wire logic       req_go,
  input  wire logic [1:0] mode,
  input  wire logic [3:0] waits,
  input  wire logic [7:0] vec,
  // Device pins
  input  wire logic       transfer_start_n,
  output logic [2:0]      irq_level_n,
  output logic [7:0]      bus_data_in,
  output logic            transfer_ack_n,
  output logic            transfer_error_ack_n,
  output logic            autovector_req_n
);
  logic [2:0] cur_q;
  logic       busy_q;
  logic       retried_q;
  logic [3:0] cnt_q;
  logic [3:0] cnt;

  assign irq_level_n = ~cur_q;
  assign cnt         = !transfer_start_n ? waits : cnt_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cur_q                <= 3'h0;
      busy_q               <= 1'b0;
      retried_q            <= 1'b0;
      cnt_q                <= 4'h0;
      transfer_ack_n       <= 1'b1;
      transfer_error_ack_n <= 1'b1;
      autovector_req_n     <= 1'b1;
      bus_data_in          <= 8'h5a;
    end else begin
      // Strobes last one cycle and change together
      transfer_ack_n       <= 1'b1;
      transfer_error_ack_n <= 1'b1;
      // Autovector-only mode ties the input asserted between cycles as well
      autovector_req_n     <= (mode != 2'h1);
      // Released data toggles each cycle, so a stale vector shows every other cycle
      bus_data_in          <= ~bus_data_in;
      if (req_go) begin
        cur_q     <= req_level;
        retried_q <= 1'b0;
      end
      if (!transfer_start_n || busy_q) begin
        if (cnt != 4'h0) begin
          busy_q <= 1'b1;
          cnt_q  <= cnt - 4'h1;
        end else begin
          busy_q <= 1'b0;
          case (mode)
            2'h0: begin
              transfer_ack_n <= 1'b0;
              bus_data_in    <= vec;
              cur_q          <= 3'h0;
            end
            2'h1: begin
              transfer_ack_n   <= 1'b0;
              autovector_req_n <= 1'b0;
              cur_q            <= 3'h0;
            end
            2'h2: begin
              // Autovector shown without acknowledge must be ignored
              transfer_error_ack_n <= 1'b0;
              autovector_req_n     <= 1'b0;
              cur_q                <= 3'h0;
            end
            default: begin
              transfer_ack_n <= 1'b0;
              if (!retried_q) begin
                transfer_error_ack_n <= 1'b0;
                retried_q            <= 1'b1;
              end else begin
                bus_data_in <= vec;
                cur_q       <= 3'h0;
              end
            end
          endcase
        end
      end
    end
  end
endmodule : iackc_peer
`default_nettype wire

// *** testbench/iackc_top_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module iackc_top_bench;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, bus_addr, rd;
  logic        avs_waitrequest, irq_pending_n, transfer_type_hi, transfer_type_lo;
  logic        bus_read, transfer_start_n, exc_take, req_go = 1'b0;
  logic        transfer_ack_n, transfer_error_ack_n, autovector_req_n;
  logic        instr_boundary = 1'b0;
  logic        higher_exc_pending = 1'b0;
  logic [2:0]  irq_level_n, transfer_modifier, req_level = 3'h0;
  logic [7:0]  bus_data_in, exc_vector, vec = 8'h00;
  logic [1:0]  exc_kind, mode = 2'h0;
  logic [3:0]  waits = 4'h0;
  int          n_mismatch = 0;
  int          checks = 0;

  iackc_top iackc_top_inst (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_level_n(irq_level_n), .irq_pending_n(irq_pending_n), .bus_addr(bus_addr),
    .transfer_type_hi(transfer_type_hi), .transfer_type_lo(transfer_type_lo),
    .transfer_modifier(transfer_modifier), .bus_read(bus_read),
    .transfer_start_n(transfer_start_n), .bus_data_in(bus_data_in),
    .transfer_ack_n(transfer_ack_n), .transfer_error_ack_n(transfer_error_ack_n),
    .autovector_req_n(autovector_req_n), .instr_boundary(instr_boundary),
    .higher_exc_pending(higher_exc_pending), .exc_take(exc_take),
    .exc_vector(exc_vector), .exc_kind(exc_kind));

  iackc_peer iackc_peer_inst (.core_clk(core_clk), .rstn(rstn), .req_level(req_level),
    .req_go(req_go), .mode(mode), .waits(waits), .vec(vec),
    .transfer_start_n(transfer_start_n), .irq_level_n(irq_level_n),
    .bus_data_in(bus_data_in), .transfer_ack_n(transfer_ack_n),
    .transfer_error_ack_n(transfer_error_ack_n), .autovector_req_n(autovector_req_n));

  always #20 core_clk = ~core_clk;

  task automatic wrap_up;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    for (i = 0; i < 16; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    if (i == 16) begin
      n_mismatch++;
      wrap_up();
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : av

  task automatic req(input logic [2:0] l);
    @(posedge core_clk);
    req_level <= l;
    req_go    <= 1'b1;
    @(posedge core_clk);
    req_go    <= 1'b0;
  endtask : req

  task automatic pulse(input logic hep);
    @(posedge core_clk);
    instr_boundary     <= 1'b1;
    higher_exc_pending <= hep;
    @(posedge core_clk);
    instr_boundary     <= 1'b0;
    higher_exc_pending <= 1'b0;
    @(negedge core_clk);
  endtask : pulse

  task automatic take(input logic [2:0] l, input logic [2:0] msk, input logic [1:0] md,
                      input logic [3:0] w, input logic [7:0] xv, input logic [1:0] xk);
    int i;
    int starts;
    av(1'b1, iackc_pkg::REG_CTRL, {29'h0, msk});
    mode  <= md;
    waits <= w;
    vec   <= 8'h66;
    req(l);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(irq_pending_n, 1'b1)
    @(negedge core_clk);
    `CHK(irq_pending_n, 1'b0)
    av(1'b0, iackc_pkg::REG_STATUS, 32'h0);
    `CHK(rd, {21'h0, l, 1'b0, l, 4'h1})
    pulse(1'b1);
    `CHK(irq_pending_n, 1'b0)
    pulse(1'b0);
    `CHK(irq_pending_n, 1'b1)
    `CHK(bus_addr, iackc_pkg::ADDR_ALL_ONES)
    `CHK({transfer_type_hi, transfer_type_lo, bus_read}, {iackc_pkg::TT_ACK, 1'b1})
    `CHK(transfer_modifier, l)
    starts = 1;
    for (i = 0; i < 40 && exc_take !== 1'b1; i++) begin
      @(negedge core_clk);
      if (transfer_start_n === 1'b0) starts++;
    end
    if (i == 40) begin
      n_mismatch++;
      wrap_up();
    end
    `CHK(i, (md == 2'h3) ? 2 * (w + 2) : w + 2)
    `CHK(starts, (md == 2'h3) ? 2 : 1)
    `CHK({exc_kind, exc_vector}, {xk, xv})
    `CHK(bus_addr, 32'h0)
    pulse(1'b0);
    av(1'b0, iackc_pkg::REG_CTRL, 32'h0);
    `CHK(rd[2:0], l)
    av(1'b0, iackc_pkg::REG_VECTOR, 32'h0);
    `CHK(rd, {22'h0, xk, xv})
  endtask : take

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    av(1'b0, iackc_pkg::REG_CTRL, 32'h0);
    `CHK(rd, {29'h0, iackc_pkg::MASK_RESET})
    av(1'b0, 4'hc, 32'h0);
    `CHK(rd, 32'h0)
    // Level equal to the mask stays ignored
    av(1'b1, iackc_pkg::REG_CTRL, 32'h5);
    req(3'h5);
    repeat (6) @(negedge core_clk);
    `CHK(irq_pending_n, 1'b1)
    // Drop the request before opening the mask, or level 5 would go pending
    req(3'h0);
    repeat (6) @(negedge core_clk);
    av(1'b1, iackc_pkg::REG_CTRL, 32'h0);
    repeat (6) @(negedge core_clk);
    `CHK(irq_pending_n, 1'b1)
    // A level held for one cycle only is a glitch
    @(posedge core_clk);
    req_level <= 3'h5;
    req_go    <= 1'b1;
    @(posedge core_clk);
    req_level <= 3'h0;
    @(posedge core_clk);
    req_go    <= 1'b0;
    repeat (6) @(negedge core_clk);
    `CHK(irq_pending_n, 1'b1)
    take(3'h3, 3'h0, 2'h0, 4'h2, 8'h66, iackc_pkg::KIND_VECTORED);
    for (int l = 1; l < 8; l++) begin
      take(l[2:0], l[2:0] - 3'h1, 2'h1, {1'b0, l[2:0]},
           iackc_pkg::AUTOVEC_BASE + {5'h0, l[2:0]}, iackc_pkg::KIND_AUTO);
    end
    take(3'h6, 3'h0, 2'h2, 4'h1, 8'h18, iackc_pkg::KIND_SPURIOUS);
    take(3'h4, 3'h0, 2'h3, 4'h0, 8'h66, iackc_pkg::KIND_VECTORED);
    wrap_up();
  end
endmodule : iackc_top_bench
`default_nettype wire
